// ---- design/cfc_defines.svh ----
// Register map, field positions, reset values and timing counts of the
// charger fault and comparator control block.
// Assumes a 40 MHz core clock; all cycle counts derive from CFC_CLK_PERIOD_NS.
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH

// ************************************************************
// Register offsets and reset values
// ************************************************************
`define CFC_ADDR_STATUS_INFO 8'h3A
`define CFC_ADDR_PRIMARY 8'h3C
`define CFC_ADDR_SECONDARY 8'h3D
`define CFC_PRIMARY_RESET 16'h0000
`define CFC_SECONDARY_RESET 16'h0000

// ************************************************************
// Field positions
// ************************************************************
`define CFC_PRI_PWRMON_BIT 3
`define CFC_PRI_OTG_EN_BIT 11
`define CFC_SEC_WOC_DIS_BIT 1
`define CFC_SEC_CMP_POL_BIT 2
`define CFC_SEC_CMP_DIS_BIT 3
`define CFC_SEC_REF_SEL_BIT 4
`define CFC_SEC_WOC_DEB_BIT 11
`define CFC_SEC_OTG_DEB_BIT 13
`define CFC_INFO_REF_BIT 15
`define CFC_INFO_OTG_HI 6
`define CFC_INFO_OTG_LO 5
`define CFC_INFO_OTG_CODE 2'h3

// ************************************************************
// Timing
// ************************************************************
`define CFC_CLK_PERIOD_NS 25
`define CFC_ADP_OV_QUAL_NS 10000
`define CFC_ADP_REL_QUAL_NS 100000
`define CFC_TEMP_REL_NS 100000
`define CFC_WOC_SLOT_NS 20000
`define CFC_WOC_WINDOW_MS 656
`define CFC_DEB_LONG_MS 1300
`define CFC_DEB_SHORT_MS 150
`define CFC_WOC_TRIP_LIMIT 3'h7
// Least times round up.
`define CFC_ADP_OV_QUAL_CYC 26'((`CFC_ADP_OV_QUAL_NS + `CFC_CLK_PERIOD_NS - 1) / `CFC_CLK_PERIOD_NS)
`define CFC_ADP_REL_QUAL_CYC 26'((`CFC_ADP_REL_QUAL_NS + `CFC_CLK_PERIOD_NS - 1) / `CFC_CLK_PERIOD_NS)
`define CFC_TEMP_REL_CYC 26'((`CFC_TEMP_REL_NS + `CFC_CLK_PERIOD_NS - 1) / `CFC_CLK_PERIOD_NS)
`define CFC_DEB_LONG_CYC 26'((`CFC_DEB_LONG_MS * 1000000 + `CFC_CLK_PERIOD_NS - 1) / `CFC_CLK_PERIOD_NS)
`define CFC_DEB_SHORT_CYC 26'((`CFC_DEB_SHORT_MS * 1000000 + `CFC_CLK_PERIOD_NS - 1) / `CFC_CLK_PERIOD_NS)
// Longest times round down.
`define CFC_WOC_SLOT_CYC 10'(`CFC_WOC_SLOT_NS / `CFC_CLK_PERIOD_NS)
`define CFC_WOC_WINDOW_CYC 26'((`CFC_WOC_WINDOW_MS * 1000000) / `CFC_CLK_PERIOD_NS)

`endif

// ---- design/cfc_pkg.sv ----
// Types shared by the charger fault and comparator control block.
// Assumes nothing beyond a SystemVerilog compiler.
package cfc_pkg;

	// ************************************************************
	// Function of the shared pin pair
	// ************************************************************
	typedef enum logic [1:0] {
		CFC_PINS_COMPARE,
		CFC_PINS_IDLE,
		CFC_PINS_REVERSE
	} cfc_pin_mode_type;

	// ************************************************************
	// Way overcurrent guard states
	// ************************************************************
	typedef enum logic {
		CFC_WOC_ARMED,
		CFC_WOC_SHUTDOWN
	} cfc_woc_state_type;

endpackage

// ---- design/cfc_sync.sv ----
// Two-flop synchroniser bank for flags that arrive from outside the clock.
// Assumes an active-low asynchronous reset already synchronised.
`timescale 1ns/10ps
module cfc_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Raw and synchronised flags.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	// The first stage feeds only the second, to contain metastability.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_one <= '0;
			sync_out <= '0;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule

// ---- design/cfc_qualify.sv ----
// Qualification counter: flags when a condition has held for limit cycles.
// Assumes the condition is synchronous to core_clk.
`timescale 1ns/10ps
module cfc_qualify (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst_n,
	// Condition and length.
	input wire logic cond,
	input wire logic [25:0] limit,
	output logic done
);

	logic [25:0] count;

	// Restart whenever the condition lapses; saturate at the limit.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 26'h0000000;
		end else if (!cond) begin
			count <= 26'h0000000;
		end else if (count < limit) begin
			count <= count + 26'h0000001;
		end
	end

	assign done = cond && (count >= limit);

endmodule

// ---- design/cfc_fault_ctrl.sv ----
// Charger fault shutdown, recovery and shared pin pair control.
// Assumes analog thresholds arrive as digital flags and registers are
// written by an SMBus front end through the simple register port.
`timescale 1ns/10ps
`include "cfc_defines.svh"
module cfc_fault_ctrl #(
	parameter logic [25:0] WOC_WINDOW_CYC = `CFC_WOC_WINDOW_CYC,
	parameter logic [25:0] DEB_LONG_CYC = `CFC_DEB_LONG_CYC,
	parameter logic [25:0] DEB_SHORT_CYC = `CFC_DEB_SHORT_CYC
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset_n,
	// Register port from the SMBus front end.
	input wire logic reg_strobe,
	input wire logic reg_write,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// Analog threshold flags.
	input wire logic adapter_voltage_sense_over,
	input wire logic adapter_voltage_sense_below,
	input wire logic system_rail_sense_over,
	input wire logic system_rail_sense_below,
	input wire logic adapter_current_over,
	input wire logic battery_current_over,
	input wire logic temp_hot,
	input wire logic temp_cool,
	input wire logic battery_above_min,
	input wire logic adapter_present,
	input wire logic compare_above_reference,
	input wire logic reverse_supply_output_ok,
	// Shared pin pair.
	input wire logic shared_enable_or_compare_input,
	output logic shared_goodflag_or_compare_output,
	output logic shared_goodflag_or_compare_output_oe,
	// Power stage and analog controls.
	output logic input_isolation_gate,
	output logic battery_fet_gate,
	output logic adapter_present_ok,
	output logic switch_enable,
	output logic ldo_enable,
	output logic reverse_supply_active,
	output logic compare_enable,
	output logic compare_ref_2v,
	output logic reference_enable
);
	import cfc_pkg::*;

	// ************************************************************
	// Reset release and input synchronisation
	// ************************************************************
	logic rst_pipe;
	logic rst_n;
	logic [12:0] flags_s;

	// Release is synchronised so all flops leave reset on the same edge.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_pipe <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_pipe <= 1'b1;
			rst_n <= rst_pipe;
		end
	end

	cfc_sync #(.WIDTH(13)) flag_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in({adapter_voltage_sense_over, adapter_voltage_sense_below,
			system_rail_sense_over, system_rail_sense_below, adapter_current_over,
			battery_current_over, temp_hot, temp_cool, battery_above_min,
			adapter_present, compare_above_reference, reverse_supply_output_ok,
			shared_enable_or_compare_input}),
		.sync_out(flags_s)
	);

	wire adp_over_s = flags_s[12];
	wire adp_below_s = flags_s[11];
	wire sys_over_s = flags_s[10];
	wire sys_below_s = flags_s[9];
	wire adp_cur_s = flags_s[8];
	wire bat_cur_s = flags_s[7];
	wire hot_s = flags_s[6];
	wire cool_s = flags_s[5];
	wire bat_ok_s = flags_s[4];
	wire adapter_s = flags_s[3];
	wire above_s = flags_s[2];
	wire vout_ok_s = flags_s[1];
	wire enable_pin_s = flags_s[0];

	// ************************************************************
	// Registers
	// ************************************************************
	logic [15:0] primary_control;
	logic [15:0] secondary_control;
	logic [15:0] status_information;
	logic otg_active;

	wire wr_primary = reg_strobe && reg_write && (reg_addr == `CFC_ADDR_PRIMARY);
	wire wr_secondary = reg_strobe && reg_write && (reg_addr == `CFC_ADDR_SECONDARY);
	wire rd_take = reg_strobe && !reg_write;
	wire [15:0] rd_mux = (reg_addr == `CFC_ADDR_STATUS_INFO) ? status_information :
		(reg_addr == `CFC_ADDR_PRIMARY) ? primary_control :
		(reg_addr == `CFC_ADDR_SECONDARY) ? secondary_control : 16'h0000;

	// Writes to the read-only status register are dropped.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			primary_control <= `CFC_PRIMARY_RESET;
			secondary_control <= `CFC_SECONDARY_RESET;
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			if (wr_primary) primary_control <= reg_wdata;
			if (wr_secondary) secondary_control <= reg_wdata;
			reg_rvalid <= rd_take;
			if (rd_take) reg_rdata <= rd_mux;
		end
	end

	wire pwrmon_en = primary_control[`CFC_PRI_PWRMON_BIT];
	wire otg_bit = primary_control[`CFC_PRI_OTG_EN_BIT];
	wire woc_disable = secondary_control[`CFC_SEC_WOC_DIS_BIT];
	wire cmp_invert = secondary_control[`CFC_SEC_CMP_POL_BIT];
	wire cmp_disable = secondary_control[`CFC_SEC_CMP_DIS_BIT];
	wire ref_sel = secondary_control[`CFC_SEC_REF_SEL_BIT];
	wire woc_deb_short = secondary_control[`CFC_SEC_WOC_DEB_BIT];
	wire otg_deb_short = secondary_control[`CFC_SEC_OTG_DEB_BIT];

	// ************************************************************
	// Comparator and shared pin pair
	// ************************************************************
	cfc_pin_mode_type pin_mode;

	// Decode of the reverse supply bit and comparator-disable bit.
	assign pin_mode = (!cmp_disable) ? CFC_PINS_COMPARE :
		(otg_bit ? CFC_PINS_REVERSE : CFC_PINS_IDLE);

	// Reference runs with an adapter, or on battery when the monitor is on.
	wire next_ref_en = adapter_s || pwrmon_en;
	wire next_cmp_en = (pin_mode == CFC_PINS_COMPARE) && next_ref_en;
	wire cmp_level = above_s ^ cmp_invert;

	// The good flag leaves the pin only in the reverse supply pin case.
	wire next_pin_out = (pin_mode == CFC_PINS_REVERSE) ? (otg_active && vout_ok_s) :
		(next_cmp_en && cmp_level);
	wire next_pin_oe = (pin_mode != CFC_PINS_IDLE);

	// ************************************************************
	// Reverse supply request and debounce
	// ************************************************************
	wire otg_debounced;
	// In comparator pin case the pin is ignored; in reverse supply pin case it must be high; idle blocks the request.
	wire otg_request = otg_bit && bat_ok_s && (pin_mode != CFC_PINS_IDLE) &&
		((pin_mode != CFC_PINS_REVERSE) || enable_pin_s);

	cfc_qualify otg_qual (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.cond(otg_request),
		.limit(otg_deb_short ? DEB_SHORT_CYC : DEB_LONG_CYC),
		.done(otg_debounced)
	);

	// Status shows reference state and the reverse supply code.
	always_comb begin
		status_information = 16'h0000;
		status_information[`CFC_INFO_REF_BIT] = reference_enable;
		if (otg_active) begin
			status_information[`CFC_INFO_OTG_HI:`CFC_INFO_OTG_LO] = `CFC_INFO_OTG_CODE;
		end
	end

	// ************************************************************
	// Adapter overvoltage
	// ************************************************************
	logic adp_fault;
	wire adp_trip_done;
	wire adp_release_done;

	cfc_qualify adp_ov_qual (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.cond(adp_over_s && !adp_fault),
		.limit(`CFC_ADP_OV_QUAL_CYC),
		.done(adp_trip_done)
	);

	cfc_qualify adp_rel_qual (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.cond(adp_below_s && adp_fault),
		.limit(`CFC_ADP_REL_QUAL_CYC),
		.done(adp_release_done)
	);

	// ************************************************************
	// System overvoltage and over-temperature
	// ************************************************************
	logic sys_fault;
	logic temp_fault;
	wire temp_release_done;

	cfc_qualify temp_qual (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.cond(cool_s && temp_fault && !hot_s),
		.limit(`CFC_TEMP_REL_CYC),
		.done(temp_release_done)
	);

	// A fresh trip wins over a release seen in the same cycle.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			adp_fault <= 1'b0;
			sys_fault <= 1'b0;
			temp_fault <= 1'b0;
		end else begin
			adp_fault <= adp_trip_done || (adp_fault && !adp_release_done);
			sys_fault <= sys_over_s || (sys_fault && !sys_below_s);
			temp_fault <= hot_s || (temp_fault && !temp_release_done);
		end
	end

	// ************************************************************
	// Way overcurrent guard
	// ************************************************************
	cfc_woc_state_type woc_state;
	cfc_woc_state_type next_woc_state;
	logic [9:0] slot_cnt;
	logic slot_used;
	logic [2:0] trip_cnt;
	logic [25:0] window_cnt;
	wire woc_retry_done;

	// Comparators already encode the 12A and 16A thresholds.
	wire woc_trip = (adp_cur_s || bat_cur_s) && !woc_disable;
	wire slot_wrap = (slot_cnt == `CFC_WOC_SLOT_CYC - 10'h001);
	wire take = woc_trip && !slot_used && (woc_state == CFC_WOC_ARMED);
	wire window_over = (trip_cnt != 3'h0) && (window_cnt >= WOC_WINDOW_CYC - 26'h0000001);
	wire hit_limit = take && (trip_cnt + 3'h1 == `CFC_WOC_TRIP_LIMIT);

	cfc_qualify woc_qual (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.cond(woc_state == CFC_WOC_SHUTDOWN),
		.limit(woc_deb_short ? DEB_SHORT_CYC : DEB_LONG_CYC),
		.done(woc_retry_done)
	);

	// Shutdown holds through the debounce, or until the guard is disabled, then the guard re-arms.
	always_comb begin
		next_woc_state = woc_state;
		case (woc_state)
			CFC_WOC_ARMED: begin
				if (hit_limit) next_woc_state = CFC_WOC_SHUTDOWN;
			end
			CFC_WOC_SHUTDOWN: begin
				if (woc_retry_done || woc_disable) next_woc_state = CFC_WOC_ARMED;
			end
			default: next_woc_state = CFC_WOC_ARMED;
		endcase
	end

	// One count per slot keeps a stuck comparator from tripping instantly.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_cnt <= 10'h000;
			slot_used <= 1'b0;
		end else begin
			slot_cnt <= slot_wrap ? 10'h000 : slot_cnt + 10'h001;
			slot_used <= !slot_wrap && (slot_used || take);
		end
	end

	// The window opens at the first count and clears the tally on expiry, or restarts it at one if a count lands then.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			woc_state <= CFC_WOC_ARMED;
			trip_cnt <= 3'h0;
			window_cnt <= 26'h0000000;
		end else begin
			woc_state <= next_woc_state;
			if (woc_disable || hit_limit || (window_over && !take)) begin
				trip_cnt <= 3'h0;
				window_cnt <= 26'h0000000;
			end else if (window_over) begin
				trip_cnt <= 3'h1;
				window_cnt <= 26'h0000000;
			end else begin
				if (take) trip_cnt <= trip_cnt + 3'h1;
				if (take || trip_cnt != 3'h0) window_cnt <= window_cnt + 26'h0000001;
			end
		end
	end

	// ************************************************************
	// Output stage
	// ************************************************************
	wire woc_shut = (woc_state == CFC_WOC_SHUTDOWN);
	wire input_ok = !adp_fault && !woc_shut;
	wire next_switch = input_ok && !sys_fault && !temp_fault;
	// Battery FET carries the load when adapter overvoltage cuts the path or the adapter is absent.
	wire next_bfet = adp_fault || !adapter_s;

	// All outputs leave flops so downstream drivers never see decode glitches.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			input_isolation_gate <= 1'b0;
			battery_fet_gate <= 1'b0;
			adapter_present_ok <= 1'b0;
			switch_enable <= 1'b0;
			ldo_enable <= 1'b0;
			otg_active <= 1'b0;
			reverse_supply_active <= 1'b0;
			compare_enable <= 1'b0;
			compare_ref_2v <= 1'b0;
			reference_enable <= 1'b0;
			shared_goodflag_or_compare_output <= 1'b0;
			shared_goodflag_or_compare_output_oe <= 1'b0;
		end else begin
			input_isolation_gate <= input_ok;
			battery_fet_gate <= next_bfet;
			adapter_present_ok <= input_ok && adapter_s;
			switch_enable <= next_switch;
			ldo_enable <= !temp_fault;
			otg_active <= otg_debounced && next_switch;
			reverse_supply_active <= otg_debounced && next_switch;
			compare_enable <= next_cmp_en;
			compare_ref_2v <= ref_sel;
			reference_enable <= next_ref_en;
			shared_goodflag_or_compare_output <= next_pin_out;
			shared_goodflag_or_compare_output_oe <= next_pin_oe;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_cmp_polarity: assert property (next_cmp_en |=>
		shared_goodflag_or_compare_output == $past(above_s ^ cmp_invert))
		else $error("comparator output polarity wrong");
	a_cmp_batt_only: assert property (!adapter_s && !pwrmon_en |=>
		!compare_enable && !status_information[`CFC_INFO_REF_BIT])
		else $error("comparator enabled on battery without monitor");
	a_pin_idle: assert property (!otg_bit && cmp_disable |=>
		!shared_goodflag_or_compare_output_oe && !compare_enable)
		else $error("shared pins driven while idle");
	a_otg_code: assert property (otg_active && rd_take &&
		(reg_addr == `CFC_ADDR_STATUS_INFO) |=>
		reg_rdata[`CFC_INFO_OTG_HI:`CFC_INFO_OTG_LO] == `CFC_INFO_OTG_CODE)
		else $error("reverse supply code missing");
	a_otg_pin_gate: assert property (pin_mode == CFC_PINS_REVERSE && !enable_pin_s
		|-> ##2 !otg_active)
		else $error("reverse supply ran without enable pin");
	a_adp_shut: assert property (adp_fault |=> !input_isolation_gate &&
		!adapter_present_ok && !switch_enable && battery_fet_gate)
		else $error("adapter overvoltage not handled");
	a_adp_qualified: assert property ($rose(adp_fault) |-> $past(adp_over_s, 2))
		else $error("adapter fault without qualified overvoltage");
	a_sys_resume: assert property (sys_fault && sys_below_s && !sys_over_s |=>
		!sys_fault)
		else $error("system overvoltage release late");
	a_sys_stop: assert property (sys_over_s |=> ##1 !switch_enable)
		else $error("switching during system overvoltage");
	a_woc_shut: assert property (hit_limit |=> woc_shut ##1
		(!input_isolation_gate && !adapter_present_ok && !switch_enable))
		else $error("overcurrent shutdown missing");
	a_woc_off: assert property (woc_disable |=> trip_cnt == 3'h0 && !woc_shut)
		else $error("overcurrent guard counted while disabled");
	a_temp_off: assert property (temp_fault |=> !ldo_enable && !switch_enable)
		else $error("regulator on during over-temperature");
	a_ref_select: assert property ($changed(ref_sel) |=> compare_ref_2v == $past(ref_sel))
		else $error("reference select not applied");

	c_otg_run: cover property ($rose(otg_active));
	c_adp_cycle: cover property ($fell(adp_fault));
	c_woc_retry: cover property (woc_shut ##1 !woc_shut);
	c_temp_recover: cover property ($fell(temp_fault));

endmodule

// ---- sim/cfc_analog_model.sv ----
// Behavioural model of the analog sensors and power stage beside the block.
// Assumes the bench sets quantities in mV, mA and degrees C as plain numbers.
`timescale 1ns/10ps
module cfc_analog_model #(
	parameter int CEIL_MV = 8400
) (
	// Analog quantities set by the bench.
	input wire logic [15:0] adp_mv,
	input wire logic [15:0] sys_mv,
	input wire logic [15:0] adp_ma,
	input wire logic [15:0] bat_ma,
	input wire logic [15:0] temp_c,
	input wire logic [15:0] bat_mv,
	input wire logic [15:0] cmp_mv,
	// Controls from the block.
	input wire logic ref_2v,
	input wire logic supply_on,
	// Threshold flags towards the block.
	output logic adp_over,
	output logic adp_below,
	output logic sys_over,
	output logic sys_below,
	output logic adp_cur_over,
	output logic bat_cur_over,
	output logic hot,
	output logic cool,
	output logic bat_ok,
	output logic cmp_above,
	output logic out_ok
);
	// ************************************************************
	// Threshold comparators
	// ************************************************************
	// Hysteresis bands leave both flags low in between, as the real sensors do.
	assign adp_over = adp_mv > 16'h5B68;
	assign adp_below = adp_mv < 16'h5A00;
	assign sys_over = sys_mv > CEIL_MV + 600;
	assign sys_below = sys_mv < CEIL_MV + 300;
	assign adp_cur_over = adp_ma > 16'h2EE0;
	assign bat_cur_over = bat_ma > 16'h3E80;
	assign hot = temp_c > 16'h008C;
	assign cool = temp_c < 16'h0078;
	assign bat_ok = bat_mv > 16'h16A8;
	assign cmp_above = cmp_mv > (ref_2v ? 16'h07D0 : 16'h04B0);
	// The supply output is only good while the reverse stage runs.
	assign out_ok = supply_on;
endmodule

// ---- sim/tb.sv ----
// Self-checking bench of the charger fault and comparator control block.
// Assumes the analog model drives every threshold flag of the block except adapter_present.
`timescale 1ns/10ps
module tb;
	logic core_clk = 1'b0, reset_n = 1'b0, reg_strobe = 1'b0, reg_write = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, adp_mv = 16'h4E20, sys_mv = 16'h20D0;
	logic [15:0] adp_ma = 16'h0000, bat_ma = 16'h0000, temp_c = 16'h0019;
	logic [15:0] bat_mv = 16'h1770, cmp_mv = 16'h0000;
	logic adapter_present = 1'b1, pin_in = 1'b0, reg_rvalid, pin_out, pin_oe, iso, bfet;
	logic ok, sw, ldo, rs_on, cmp_en, ref2, ref_en, f_ao, f_ab, f_so, f_sb, f_ac, f_bc;
	logic f_h, f_c, f_b, f_cmp, f_ok;
	logic [31:0] seed = 32'h7F54A47B;
	int err_total = 0, n_tests = 0, i;
	// ************************************************************
	// Clock, reset, watchdog
	// ************************************************************
	initial forever #12.5 core_clk = ~core_clk;
	initial begin
		#(25 * 60000);
		err_total++;
		report_and_stop();
	end
	cfc_fault_ctrl #(.WOC_WINDOW_CYC(26'h1F40), .DEB_LONG_CYC(26'h12C), .DEB_SHORT_CYC(26'h64)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .reg_strobe(reg_strobe), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .adapter_voltage_sense_over(f_ao),
		.adapter_voltage_sense_below(f_ab), .system_rail_sense_over(f_so),
		.system_rail_sense_below(f_sb), .adapter_current_over(f_ac),
		.battery_current_over(f_bc), .temp_hot(f_h), .temp_cool(f_c),
		.battery_above_min(f_b), .adapter_present(adapter_present),
		.compare_above_reference(f_cmp), .reverse_supply_output_ok(f_ok),
		.shared_enable_or_compare_input(pin_in), .shared_goodflag_or_compare_output(pin_out),
		.shared_goodflag_or_compare_output_oe(pin_oe), .input_isolation_gate(iso),
		.battery_fet_gate(bfet), .adapter_present_ok(ok), .switch_enable(sw),
		.ldo_enable(ldo), .reverse_supply_active(rs_on), .compare_enable(cmp_en),
		.compare_ref_2v(ref2), .reference_enable(ref_en));
	cfc_analog_model model (.adp_mv(adp_mv), .sys_mv(sys_mv), .adp_ma(adp_ma), .bat_ma(bat_ma),
		.temp_c(temp_c), .bat_mv(bat_mv), .cmp_mv(cmp_mv), .ref_2v(ref2), .supply_on(rs_on),
		.adp_over(f_ao), .adp_below(f_ab), .sys_over(f_so), .sys_below(f_sb),
		.adp_cur_over(f_ac), .bat_cur_over(f_bc), .hot(f_h), .cool(f_c), .bat_ok(f_b),
		.cmp_above(f_cmp), .out_ok(f_ok));
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected pin level: input against the selected reference, then polarity.
	function automatic logic exp_cmp(input logic [15:0] mv, input logic sel, input logic inv);
		return (mv > (sel ? 16'h07D0 : 16'h04B0)) ^ inv;
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		reg_strobe = 1'b1;
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick(1);
		reg_strobe = 1'b0;
		tick(2);
	endtask
	// Reads wait a bounded number of cycles for the answer pulse.
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		int k;
		reg_strobe = 1'b1;
		reg_write = 1'b0;
		reg_addr = a;
		tick(1);
		reg_strobe = 1'b0;
		for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++) tick(1);
		chk({15'h0000, reg_rvalid}, 16'h0001);
		chk(reg_rdata, exp);
		tick(1);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		tick(5);
		reset_n = 1'b1;
		tick(10);
		rd(8'h3C, 16'h0000);
		rd(8'h3D, 16'h0000);
		rd(8'h50, 16'h0000);
		rd(8'h3A, 16'h8000);
		$display("test registers done");
		for (i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			wr(8'h3D, {11'h000, seed[0], 1'b0, seed[1], 2'h0});
			cmp_mv = {4'h0, seed[31:20]};
			tick(8);
			chk({15'h0000, pin_out}, {15'h0000, exp_cmp(cmp_mv, seed[0], seed[1])});
			chk({13'h0000, ref2, pin_oe, cmp_en}, {13'h0000, seed[0], 2'h3});
		end
		wr(8'h3D, 16'h0008);
		chk({14'h0000, pin_oe, rs_on}, 16'h0000);
		wr(8'h3D, 16'h0000);
		adapter_present = 1'b0;
		tick(8);
		chk({14'h0000, cmp_en, ref_en}, 16'h0000);
		wr(8'h3C, 16'h0008);
		tick(8);
		chk({14'h0000, cmp_en, ref_en}, 16'h0003);
		adapter_present = 1'b1;
		wr(8'h3C, 16'h0000);
		$display("test comparator done");
		adp_mv = 16'h5DC0;
		tick(380);
		chk({12'h000, iso, ok, bfet, sw}, 16'h000D);
		tick(40);
		chk({12'h000, iso, ok, bfet, sw}, 16'h0002);
		adp_mv = 16'h4E20;
		tick(4020);
		chk({13'h0000, iso, ok, sw}, 16'h0007);
		$display("test adapter done");
		sys_mv = 16'h23F0;
		tick(6);
		chk({15'h0000, sw}, 16'h0000);
		sys_mv = 16'h20D0;
		tick(6);
		chk({15'h0000, sw}, 16'h0001);
		temp_c = 16'h0096;
		tick(8);
		chk({14'h0000, ldo, sw}, 16'h0000);
		temp_c = 16'h0064;
		tick(4020);
		chk({14'h0000, ldo, sw}, 16'h0003);
		$display("test rail and heat done");
		wr(8'h3D, 16'h0800);
		bat_ma = 16'h3E90;
		// Seven counts at one per slot need at least five whole slots.
		for (i = 0; i < 7 * 800 + 20 && iso !== 1'b0; i++) tick(1);
		chk({15'h0000, i >= 4000}, 16'h0001);
		chk({13'h0000, iso, ok, sw}, 16'h0000);
		tick(90);
		chk({13'h0000, iso, ok, sw}, 16'h0000);
		bat_ma = 16'h0000;
		tick(20);
		chk({13'h0000, iso, ok, sw}, 16'h0007);
		// With the guard disabled a lasting trip must never cut the input.
		wr(8'h3D, 16'h0802);
		bat_ma = 16'h3E90;
		for (i = 0; i < 7 * 800 + 20 && iso === 1'b1; i++) tick(1);
		chk({15'h0000, iso}, 16'h0001);
		bat_ma = 16'h0000;
		$display("test overcurrent done");
		wr(8'h3D, 16'h2008);
		wr(8'h3C, 16'h0800);
		pin_in = 1'b1;
		tick(60);
		chk({15'h0000, rs_on}, 16'h0000);
		tick(80);
		chk({13'h0000, rs_on, pin_oe, pin_out}, 16'h0007);
		rd(8'h3A, 16'h8060);
		pin_in = 1'b0;
		tick(6);
		chk({14'h0000, rs_on, pin_out}, 16'h0000);
		wr(8'h3D, 16'h2000);
		tick(110);
		chk({13'h0000, rs_on, pin_oe, cmp_en}, 16'h0007);
		rd(8'h3C, 16'h0800);
		$display("test reverse supply done");
		report_and_stop();
	end
endmodule
